// *** srg_pkg.sv ***
// Shared constants for the supply supervisor, RAM gate and command decoder
package srg_pkg;

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  localparam int XTAL_HZ = 32768;
  localparam int CLK_MHZ = 100;
  localparam int RESET_TIME_MS = 250;
  localparam int RESET_TICKS = (RESET_TIME_MS * XTAL_HZ + 999) / 1000;
  localparam int WDOG_TIME_MS = 1000;
  localparam int WDOG_TICKS = (WDOG_TIME_MS * XTAL_HZ) / 1000;
  localparam int DEBOUNCE_TIME_MS = 10;
  localparam int DEBOUNCE_TICKS = (DEBOUNCE_TIME_MS * XTAL_HZ + 999) / 1000;
  localparam int XTAL_LOSS_US = 122;
  localparam int XTAL_LOSS_CYCLES = XTAL_LOSS_US * CLK_MHZ;
  localparam int TICK_W = 16;
  localparam int LOSS_W = 16;

  // ------------------------------------------------------------
  // Synchroniser lanes
  // ------------------------------------------------------------
  localparam int SY_XTAL = 0;
  localparam int SY_KICK = 1;
  localparam int SY_RSTIN = 2;
  localparam int SY_LOWER = 3;
  localparam int SY_UPPER = 4;
  localparam int SY_CEI = 5;
  localparam int SY_PFAIL = 6;
  localparam int SY_SUPOK = 7;
  localparam int SY_W = 8;
  localparam logic [SY_W-1:0] SY_RST = 8'h7e;

  // ------------------------------------------------------------
  // Command byte
  // ------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int CMD_ADDR_W = 7;
  localparam int CMD_RW_BIT = 7;
  localparam logic [3:0] CMD_LAST = 4'h8;
  localparam logic CMD_READ = 1'h0;
  localparam logic CMD_WRITE = 1'h1;

  // ------------------------------------------------------------
  // Reset pin state machine
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RS_IDLE = 3'h1,
    RS_PULSE = 3'h2,
    RS_RELEASE = 3'h4
  } srg_rst_state_t;

endpackage

// *** srg_supervisor.sv ***
// Supply supervisor, SRAM byte gate, watchdog and serial command decoder
`timescale 1ns/1ns
module srg_supervisor
  import srg_pkg::*;
#(
  parameter int RESET_TICKS_P = RESET_TICKS,
  parameter int WDOG_TICKS_P = WDOG_TICKS,
  parameter int LOSS_CYCLES_P = XTAL_LOSS_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Supply monitor and crystal
  input wire logic supply_ok,
  input wire logic power_fail,
  input wire logic xtal_clk,
  // SRAM gate
  input wire logic ram_select_in_n,
  input wire logic upper_byte_sel_n,
  input wire logic lower_byte_sel_n,
  output logic ram_select_low_n,
  output logic ram_select_high_n,
  // Alarm
  input wire logic alarm_pending_flag,
  input wire logic alarm_irq_gate,
  output logic alarm_request_out,
  // Processor reset pin and watchdog
  input wire logic watchdog_kick_n,
  input wire logic cpu_reset_in,
  output logic cpu_reset_out,
  output logic cpu_reset_oe_n,
  output logic device_ready,
  // Serial link
  input wire logic serial_clk,
  input wire logic serial_select,
  input wire logic serial_data_in,
  // Decoded command
  output logic [CMD_ADDR_W-1:0] cmd_addr,
  output logic cmd_write,
  output logic cmd_strobe
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic edge_of(input logic prev, input logic cur, input logic rising);
    edge_of = rising ? (cur & ~prev) : (prev & ~cur);
  endfunction

  function automatic logic [TICK_W-1:0] step(input logic [TICK_W-1:0] v, input logic en);
    step = en ? v + 16'h0001 : v;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [SY_W-1:0] sy_a;
  logic [SY_W-1:0] sy_b;
  logic [SY_W-1:0] sy_c;
  logic [SY_W-1:0] next_sy_a;
  logic [SY_W-1:0] next_sy_b;
  logic [SY_W-1:0] next_sy_c;
  logic [SY_W-1:0] pins;
  assign pins = {supply_ok, power_fail, ram_select_in_n, upper_byte_sel_n,
                 lower_byte_sel_n, cpu_reset_in, watchdog_kick_n, xtal_clk};
  always_comb begin
    next_sy_a = pins;
    next_sy_b = sy_a;
    next_sy_c = sy_b;
    if (!rst_n) begin
      next_sy_a = SY_RST;
      next_sy_b = SY_RST;
      next_sy_c = SY_RST;
    end
  end
  always_ff @(posedge clk) begin
    sy_a <= next_sy_a;
    sy_b <= next_sy_b;
    sy_c <= next_sy_c;
  end

  // ------------------------------------------------------------
  // Crystal tick and loss detect
  // ------------------------------------------------------------
  logic tick;
  logic [LOSS_W-1:0] loss_cnt;
  logic [LOSS_W-1:0] next_loss_cnt;
  logic xtal_alive;
  logic next_xtal_alive;
  assign tick = edge_of(sy_c[SY_XTAL], sy_b[SY_XTAL], 1'b1);
  always_comb begin
    next_loss_cnt = loss_cnt;
    next_xtal_alive = xtal_alive;
    if (tick) begin
      next_loss_cnt = '0;
      next_xtal_alive = 1'b1;
    end else if (loss_cnt == LOSS_W'(LOSS_CYCLES_P - 1)) begin
      next_xtal_alive = 1'b0;
    end else begin
      next_loss_cnt = loss_cnt + 16'h0001;
    end
    if (!rst_n) begin
      next_loss_cnt = '0;
      next_xtal_alive = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    loss_cnt <= next_loss_cnt;
    xtal_alive <= next_xtal_alive;
  end

  // ------------------------------------------------------------
  // Reset pin, lockout, debounce and watchdog
  // ------------------------------------------------------------
  srg_rst_state_t state;
  srg_rst_state_t next_state;
  logic [TICK_W-1:0] pulse_cnt;
  logic [TICK_W-1:0] next_pulse_cnt;
  logic [TICK_W-1:0] deb_cnt;
  logic [TICK_W-1:0] next_deb_cnt;
  logic [TICK_W-1:0] wdog_cnt;
  logic [TICK_W-1:0] next_wdog_cnt;
  logic lockout;
  logic next_lockout;
  logic power_good;
  logic kick_fall;
  logic button_hit;
  logic wdog_hit;
  assign power_good = sy_b[SY_SUPOK] & ~sy_b[SY_PFAIL] & xtal_alive;
  assign kick_fall = edge_of(sy_c[SY_KICK], sy_b[SY_KICK], 1'b0);
  assign button_hit = ~sy_b[SY_RSTIN] & (deb_cnt == TICK_W'(DEBOUNCE_TICKS - 1)) & tick;
  assign wdog_hit = (wdog_cnt == TICK_W'(WDOG_TICKS_P - 1)) & tick;
  always_comb begin
    next_state = state;
    next_pulse_cnt = pulse_cnt;
    next_deb_cnt = deb_cnt;
    next_wdog_cnt = step(wdog_cnt, tick);
    next_lockout = lockout;
    if (kick_fall && !lockout) begin
      next_wdog_cnt = '0;
    end
    case (state)
      RS_IDLE: begin
        next_deb_cnt = sy_b[SY_RSTIN] ? '0 : step(deb_cnt, tick);
        if (button_hit || wdog_hit) begin
          next_state = RS_PULSE;
          next_pulse_cnt = '0;
        end
      end
      RS_PULSE: begin
        next_wdog_cnt = '0;
        next_deb_cnt = '0;
        next_pulse_cnt = step(pulse_cnt, tick);
        if (tick && pulse_cnt == TICK_W'(RESET_TICKS_P - 1)) begin
          next_state = RS_RELEASE;
          next_lockout = 1'b0;
        end
      end
      RS_RELEASE: begin
        // Wait for the pull-up so our own drive is not seen as a press
        next_wdog_cnt = '0;
        next_deb_cnt = '0;
        if (sy_b[SY_RSTIN]) begin
          next_state = RS_IDLE;
        end
      end
      default: begin
        next_state = RS_PULSE;
        next_pulse_cnt = '0;
      end
    endcase
    if (!power_good) begin
      next_state = RS_PULSE;
      next_pulse_cnt = '0;
      next_lockout = 1'b1;
    end
    if (!rst_n) begin
      next_state = RS_PULSE;
      next_pulse_cnt = '0;
      next_deb_cnt = '0;
      next_wdog_cnt = '0;
      next_lockout = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    state <= next_state;
    pulse_cnt <= next_pulse_cnt;
    deb_cnt <= next_deb_cnt;
    wdog_cnt <= next_wdog_cnt;
    lockout <= next_lockout;
  end

  // ------------------------------------------------------------
  // Output pins
  // ------------------------------------------------------------
  logic next_low_n;
  logic next_high_n;
  logic next_alarm;
  logic next_oe_n;
  logic ram_ok;
  assign ram_ok = power_good & ~lockout & ~sy_b[SY_CEI];
  always_comb begin
    next_low_n = ~(ram_ok & ~sy_b[SY_LOWER]);
    next_high_n = ~(ram_ok & ~sy_b[SY_UPPER]);
    next_alarm = alarm_pending_flag & alarm_irq_gate;
    next_oe_n = (state != RS_PULSE);
    if (!rst_n) begin
      next_low_n = 1'b1;
      next_high_n = 1'b1;
      next_alarm = 1'b0;
      next_oe_n = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    ram_select_low_n <= next_low_n;
    ram_select_high_n <= next_high_n;
    alarm_request_out <= next_alarm;
    cpu_reset_oe_n <= next_oe_n;
  end

  // Pin only ever pulls low; the pull-up makes the high level
  assign cpu_reset_out = 1'b0;
  assign device_ready = ~lockout;

  // ------------------------------------------------------------
  // Serial link domain
  // ------------------------------------------------------------
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic link_done;
  logic next_link_done;
  logic [CMD_BITS-1:0] shift;
  logic [CMD_BITS-1:0] next_shift;

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_link_done = link_done;
    next_shift = shift;
    if (bit_cnt != CMD_LAST) begin
      // Command byte arrives least significant bit first
      next_shift = {serial_data_in, shift[CMD_BITS-1:1]};
      next_bit_cnt = bit_cnt + 4'h1;
      next_link_done = (bit_cnt == CMD_LAST - 4'h1);
    end
  end
  always_ff @(posedge serial_clk or negedge serial_select) begin
    if (!serial_select) begin
      bit_cnt <= 4'h0;
      link_done <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      link_done <= next_link_done;
    end
  end

  // Shift register freezes after eight bits, so it is stable when read across
  always_ff @(posedge serial_clk) begin
    shift <= next_shift;
  end

  // ------------------------------------------------------------
  // Command capture
  // ------------------------------------------------------------
  logic dn_a;
  logic dn_b;
  logic dn_c;
  logic [CMD_ADDR_W-1:0] next_cmd_addr;
  logic next_cmd_write;
  logic next_cmd_strobe;
  always_comb begin
    next_cmd_addr = cmd_addr;
    next_cmd_write = cmd_write;
    next_cmd_strobe = 1'b0;
    if (edge_of(dn_c, dn_b, 1'b1) && !lockout) begin
      next_cmd_addr = shift[CMD_ADDR_W-1:0];
      next_cmd_write = (shift[CMD_RW_BIT] == CMD_WRITE);
      next_cmd_strobe = 1'b1;
    end
    if (!rst_n) begin
      next_cmd_addr = '0;
      next_cmd_write = CMD_READ;
    end
  end

  always_ff @(posedge clk) begin
    dn_a <= rst_n ? link_done : 1'b0;
    dn_b <= rst_n ? dn_a : 1'b0;
    dn_c <= rst_n ? dn_b : 1'b0;
    cmd_addr <= next_cmd_addr;
    cmd_write <= next_cmd_write;
    cmd_strobe <= next_cmd_strobe;
  end

endmodule

// *** srg_props.sv ***
// Checker for the supervisor pin behaviour
`timescale 1ns/1ns
module srg_props (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_fail,
  input wire logic ram_select_in_n,
  input wire logic upper_byte_sel_n,
  input wire logic lower_byte_sel_n,
  input wire logic ram_select_low_n,
  input wire logic ram_select_high_n,
  input wire logic alarm_pending_flag,
  input wire logic alarm_irq_gate,
  input wire logic alarm_request_out,
  input wire logic cpu_reset_out,
  input wire logic cpu_reset_oe_n,
  input wire logic device_ready,
  input wire logic cmd_strobe
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Two sync flops and a register lie between pin and select
  property p_low;
    !ram_select_low_n |-> !$past(ram_select_in_n, 3) && !$past(lower_byte_sel_n, 3);
  endproperty
  property p_high;
    !ram_select_high_n |-> !$past(ram_select_in_n, 3) && !$past(upper_byte_sel_n, 3);
  endproperty
  property p_pfail;
    power_fail |-> ##3 (ram_select_low_n && ram_select_high_n);
  endproperty
  property p_ready;
    !device_ready |-> ram_select_low_n && ram_select_high_n;
  endproperty
  property p_alarm_on;
    alarm_pending_flag && alarm_irq_gate |=> alarm_request_out;
  endproperty
  property p_alarm_off;
    !(alarm_pending_flag && alarm_irq_gate) |=> !alarm_request_out;
  endproperty
  property p_od;
    !cpu_reset_out;
  endproperty
  property p_pulse;
    $fell(cpu_reset_oe_n) |=> !cpu_reset_oe_n [*8];
  endproperty
  property p_strobe;
    cmd_strobe |-> device_ready ##1 !cmd_strobe;
  endproperty
  a_low: assert property (p_low) else $error("low select without request");
  a_high: assert property (p_high) else $error("high select without request");
  a_pfail: assert property (p_pfail) else $error("select during power fail");
  a_ready: assert property (p_ready) else $error("select during lockout");
  a_alarm_on: assert property (p_alarm_on) else $error("alarm missing");
  a_alarm_off: assert property (p_alarm_off) else $error("alarm not gated");
  a_od: assert property (p_od) else $error("reset pin driven high");
  a_pulse: assert property (p_pulse) else $error("reset pulse too short");
  a_strobe: assert property (p_strobe) else $error("bad command strobe");
  c_cmd: cover property (cmd_strobe);
  c_word: cover property (!ram_select_low_n && !ram_select_high_n);
  c_pulse: cover property ($fell(cpu_reset_oe_n) && device_ready);
endmodule

// *** srg_host.sv ***
// Host, serial master and pushbutton model
`timescale 1ns/1ns
module srg_host (
  // Serial link
  output logic serial_clk = 1'h0,
  output logic serial_select = 1'h1,
  output logic serial_data_in = 1'h0,
  // Watchdog and reset pin
  output logic watchdog_kick_n = 1'h1,
  output logic cpu_reset_in,
  input wire logic cpu_reset_out,
  input wire logic cpu_reset_oe_n
);
  logic button_n = 1'h1;
  logic kick_en = 1'h0;
  // Link logic has no system reset; one falling select edge clears its counter
  initial #20 serial_select = 1'h0;
  assign cpu_reset_in = (cpu_reset_oe_n | cpu_reset_out) & button_n;
  always begin
    #500;
    if (kick_en) watchdog_kick_n = 1'h0;
    #100;
    watchdog_kick_n = 1'h1;
  end
  task automatic send(input logic [7:0] b);
    serial_select = 1'h1;
    for (int i = 0; i < 8; i++) begin
      serial_data_in = b[i];
      #16 serial_clk = 1'h1;
      #16 serial_clk = 1'h0;
    end
    #64 serial_select = 1'h0;
    // Released line shows no stale bit
    serial_data_in = ~b[7];
    // Select stays low between frames; the frame ends on a select fall
    #40;
  endtask
endmodule

// *** test_supervisor_ram_gate_cmd_decode.sv ***
// Self-checking bench for the supervisor, RAM gate and decoder
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h expected %h", $time, g, e); end end
module test_supervisor_ram_gate_cmd_decode;
  import srg_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, supply_ok = 1'h1, power_fail = 1'h0, xtal_clk = 1'h0;
  logic ram_select_in_n = 1'h0, upper_byte_sel_n = 1'h0, lower_byte_sel_n = 1'h0;
  logic alarm_pending_flag = 1'h0, alarm_irq_gate = 1'h0;
  logic ram_select_low_n, ram_select_high_n, alarm_request_out, device_ready;
  logic cpu_reset_out, cpu_reset_oe_n, cmd_write, cmd_strobe, cpu_reset_in;
  logic serial_clk, serial_select, serial_data_in, watchdog_kick_n;
  logic [CMD_ADDR_W-1:0] cmd_addr;
  logic [7:0] b;
  logic [7:0] q[$];
  int fails = 0, compares = 0, n;
  always #5 clk = ~clk;
  // Crystal shortened to 200 ns so debounce fits the run
  always #100 xtal_clk = ~xtal_clk;
  srg_supervisor #(.RESET_TICKS_P(8), .WDOG_TICKS_P(16), .LOSS_CYCLES_P(60)) i_dut (
    .clk, .rst_n, .supply_ok, .power_fail, .xtal_clk, .ram_select_in_n, .upper_byte_sel_n,
    .lower_byte_sel_n, .ram_select_low_n, .ram_select_high_n, .alarm_pending_flag,
    .alarm_irq_gate, .alarm_request_out, .watchdog_kick_n, .cpu_reset_in, .cpu_reset_out,
    .cpu_reset_oe_n, .device_ready, .serial_clk, .serial_select, .serial_data_in, .cmd_addr,
    .cmd_write, .cmd_strobe);
  srg_host i_host (.serial_clk, .serial_select, .serial_data_in, .watchdog_kick_n,
    .cpu_reset_in, .cpu_reset_out, .cpu_reset_oe_n);
  // ----
  // Tasks
  // ----
  task end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 20000) begin
      @(negedge clk);
      k++;
    end
    n = k;
    if (k == 20000) begin
      fails++;
      end_sim();
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    void'($urandom(42));
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    repeat (50) @(negedge clk);
    `CHK({ram_select_low_n, ram_select_high_n}, 2'h3)
    wait_for(device_ready, 1'h1);
    `CHK(n > 100, 1'h1)
    repeat (3) @(negedge clk);
    `CHK(cpu_reset_oe_n, 1'h1)
    i_host.kick_en = 1'h1;
    $display("lockout test done");
    for (int i = 0; i < 24; i++) begin
      {ram_select_in_n, upper_byte_sel_n, lower_byte_sel_n} = i < 8 ? i[2:0] : 3'($urandom);
      {alarm_pending_flag, alarm_irq_gate} = i[1:0];
      repeat (4) @(negedge clk);
      `CHK(ram_select_low_n, ram_select_in_n | lower_byte_sel_n)
      `CHK(ram_select_high_n, ram_select_in_n | upper_byte_sel_n)
      `CHK(alarm_request_out, alarm_pending_flag & alarm_irq_gate)
    end
    $display("gate test done");
    for (int i = 0; i < 6; i++) begin
      b = {i[0], 7'($urandom)};
      q.push_back(b);
      fork
        i_host.send(b);
        wait_for(cmd_strobe, 1'h1);
      join
      b = q.pop_front();
      `CHK(cmd_addr, b[6:0])
      `CHK(cmd_write, b[7])
    end
    $display("command test done");
    {ram_select_in_n, upper_byte_sel_n, lower_byte_sel_n} = 3'h0;
    repeat (400) @(negedge clk);
    `CHK(cpu_reset_oe_n, 1'h1)
    // Stop right after a kick so the expiry time is known
    wait_for(watchdog_kick_n, 1'h0);
    i_host.kick_en = 1'h0;
    wait_for(cpu_reset_oe_n, 1'h0);
    `CHK(n inside {[250:345]}, 1'h1)
    wait_for(cpu_reset_oe_n, 1'h1);
    `CHK(n inside {[140:180]}, 1'h1)
    $display("watchdog test done");
    i_host.kick_en = 1'h1;
    // Let the device see the released pin before the press
    repeat (4) @(negedge clk);
    i_host.button_n = 1'h0;
    wait_for(cpu_reset_oe_n, 1'h0);
    `CHK(n > 6400, 1'h1)
    i_host.button_n = 1'h1;
    wait_for(cpu_reset_oe_n, 1'h1);
    `CHK(n > 140, 1'h1)
    $display("button test done");
    power_fail = 1'h1;
    supply_ok = 1'h0;
    repeat (5) @(negedge clk);
    `CHK({ram_select_low_n, ram_select_high_n}, 2'h3)
    `CHK(cpu_reset_oe_n, 1'h0)
    $display("power fail test done");
    end_sim();
  end
endmodule
bind srg_supervisor srg_props i_props (.clk, .rst_n, .power_fail, .ram_select_in_n,
  .upper_byte_sel_n, .lower_byte_sel_n, .ram_select_low_n, .ram_select_high_n,
  .alarm_pending_flag, .alarm_irq_gate, .alarm_request_out, .cpu_reset_out,
  .cpu_reset_oe_n, .device_ready, .cmd_strobe);
